// *** dlc_consts.vh ***
// Constants for the line control register bank: register addresses,
// field positions, reset values and ring-hold timing.
// Assumes a 40 MHz clock and an 8-bit register port with 5-bit address.
`ifndef DLC_CONSTS_VH
`define DLC_CONSTS_VH

// Register addresses
`define DLC_ADDR_CONTROL_ONE 5'h01
`define DLC_ADDR_CONTROL_TWO 5'h02
`define DLC_ADDR_RESERVED_THREE 5'h03
`define DLC_ADDR_RESERVED_FOUR 5'h04
`define DLC_ADDR_LINE_HOOK 5'h05

// Reset values
`define DLC_RST_CONTROL_ONE 8'h00
`define DLC_RST_CONTROL_TWO 8'h03
`define DLC_RST_LINE_HOOK 8'h00

// Field positions
`define DLC_BIT_SOFT_RESET 7
`define DLC_BIT_ISO_LOOP 1
`define DLC_BIT_ECHO_LOOP 3
`define DLC_BIT_HYBRID 1
`define DLC_BIT_RX_ON 0
`define DLC_BIT_RING_NEG 6
`define DLC_BIT_RING_POS 5
`define DLC_BIT_MONITOR 3
`define DLC_BIT_RING_ACT 2
`define DLC_BIT_SEIZE 0

// Ring active hold: released between 4.5 s and 9 s after last positive ring
`define DLC_CLK_HZ 40000000
`define DLC_RING_HOLD_MS 4500
`define DLC_RING_HOLD_CYCLES ((`DLC_CLK_HZ / 1000) * `DLC_RING_HOLD_MS)

`endif

// *** dlc_line_control.v ***
// Line control register bank: control one, control two, reserved three and
// four, and the hook control register, plus ring-active hold and hook logic.
// Assumes register strobes and ring/pin inputs synchronous to clk.
`default_nettype none
`include "dlc_consts.vh"

// Notes on behaviour
// - Writing one to the software reset bit restores every register to reset.
// - The software reset bit clears itself; it never reads back as one.
// - Isolation loopback bit drives the barrier digital loopback on or off.
// - Line echo loopback bit drives external analog loopback on or off.
// - Hybrid connect bit connects hybrid in transmit path; resets to one.
// - Receive path bit enables the receive path; resets to one.
// - Negative ring flag follows the negative ring detector; read only.
// - Positive ring flag follows the positive ring detector; read only.
// - Ring active clears 4.5 s after last positive ring, or on off-hook.
// - On-hook monitor bit enables low-power line monitoring for caller ID.
// - Off-hook request one seizes the line; zero leaves it on-hook.
// - Effective off-hook is request OR hook pin when the pin is gated on.
// - With mode set, going on-hook skips the off-hook counter for re-seize.
module dlc_line_control #(
   parameter RING_HOLD_CYCLES = `DLC_RING_HOLD_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire [4:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Line-side detectors and pins
   input wire ring_negative_in,
   input wire ring_positive_in,
   input wire hook_pin_gate,
   input wire hook_pin,
   input wire quick_reseize_mode,
   input wire hook_counter_done,
   // Controls to the line side
   output wire isolation_loopback_enable,
   output wire line_echo_loopback,
   output wire hybrid_connect,
   output wire receive_path_on,
   output wire onhook_monitor_enable,
   output reg line_offhook,
   output reg hook_counter_start
);

   ////////////////////////////////////////////////////////////////////////////
   // Stored control bits

   reg iso_loop;
   reg echo_loop;
   reg hybrid;
   reg rx_on;
   reg monitor;
   reg seize;
   reg ring_neg;
   reg ring_pos;
   reg ring_act;
   reg [31:0] ring_timer;

   // Cut on purpose to the timer's width; the default count fits in 32 bits
   localparam [31:0] RING_HOLD = RING_HOLD_CYCLES;

   wire soft_reset = reg_wr && (reg_addr == `DLC_ADDR_CONTROL_ONE) &&
                     reg_wdata[`DLC_BIT_SOFT_RESET];
   // Soft reset acts like rst at its own edge; the other written bits are dropped
   wire any_reset = rst || soft_reset;
   wire [7:0] rst_c2 = `DLC_RST_CONTROL_TWO;
   wire wr_c1 = reg_wr && (reg_addr == `DLC_ADDR_CONTROL_ONE);
   wire wr_c2 = reg_wr && (reg_addr == `DLC_ADDR_CONTROL_TWO);
   wire wr_hk = reg_wr && (reg_addr == `DLC_ADDR_LINE_HOOK);
   wire seize_cmd = seize || (hook_pin_gate && hook_pin);

   // Control one: only the loopback bit is stored; the reset bit is a strobe
   always @(posedge clk) begin
      if (any_reset) begin
         iso_loop <= 1'b0;
      end else if (wr_c1) begin
         iso_loop <= reg_wdata[`DLC_BIT_ISO_LOOP];
      end
   end

   always @(posedge clk) begin
      if (any_reset) begin
         echo_loop <= 1'b0;
         hybrid <= rst_c2[`DLC_BIT_HYBRID];
         rx_on <= rst_c2[`DLC_BIT_RX_ON];
      end else if (wr_c2) begin
         echo_loop <= reg_wdata[`DLC_BIT_ECHO_LOOP];
         hybrid <= reg_wdata[`DLC_BIT_HYBRID];
         rx_on <= reg_wdata[`DLC_BIT_RX_ON];
      end
   end

   always @(posedge clk) begin
      if (any_reset) begin
         monitor <= 1'b0;
         seize <= 1'b0;
      end else if (wr_hk) begin
         monitor <= reg_wdata[`DLC_BIT_MONITOR];
         seize <= reg_wdata[`DLC_BIT_SEIZE];
      end
   end

   assign isolation_loopback_enable = iso_loop;
   assign line_echo_loopback = echo_loop;
   assign hybrid_connect = hybrid;
   assign receive_path_on = rx_on;
   assign onhook_monitor_enable = monitor;

   ////////////////////////////////////////////////////////////////////////////
   // Ring flags and ring-active hold

   // Holding at the least documented time keeps software waits predictable
   always @(posedge clk) begin
      if (any_reset) begin
         ring_neg <= 1'b0;
         ring_pos <= 1'b0;
         ring_act <= 1'b0;
         ring_timer <= 32'h0;
      end else begin
         ring_neg <= ring_negative_in;
         ring_pos <= ring_positive_in;
         if (line_offhook) begin
            ring_act <= 1'b0;
            ring_timer <= 32'h0;
         end else if (ring_positive_in) begin
            ring_act <= 1'b1;
            ring_timer <= RING_HOLD;
         end else if (ring_timer > 32'h1) begin
            ring_timer <= ring_timer - 32'h1;
         end else if (ring_timer == 32'h1) begin
            ring_timer <= 32'h0;
            ring_act <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hook state and off-hook counter

   // Counter itself lives on the line side; done reports its timeout
   // A quick on-hook has its own state, so its re-seize never waits for done
   localparam [2:0] HK_ONHOOK = 3'b001;
   localparam [2:0] HK_QUICK = 3'b010;
   localparam [2:0] HK_OFFHOOK = 3'b100;

   reg [2:0] hook_state;
   reg [2:0] next_hook_state;
   reg next_counter_start;

   always @* begin
      next_hook_state = hook_state;
      next_counter_start = 1'b0;
      case (hook_state)
         HK_ONHOOK: begin
            if (seize_cmd && hook_counter_done)
               next_hook_state = HK_OFFHOOK;
         end
         HK_QUICK: begin
            if (seize_cmd)
               next_hook_state = HK_OFFHOOK;
         end
         HK_OFFHOOK: begin
            if (!seize_cmd) begin
               if (quick_reseize_mode) begin
                  next_hook_state = HK_QUICK;
               end else begin
                  next_hook_state = HK_ONHOOK;
                  next_counter_start = 1'b1;
               end
            end
         end
         default: next_hook_state = HK_ONHOOK;
      endcase
   end

   always @(posedge clk) begin
      if (any_reset) begin
         hook_state <= HK_ONHOOK;
         line_offhook <= 1'b0;
         hook_counter_start <= 1'b0;
      end else begin
         hook_state <= next_hook_state;
         line_offhook <= (next_hook_state == HK_OFFHOOK);
         hook_counter_start <= next_counter_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read-back

   always @* begin
      reg_rdata = 8'h00;
      case (reg_addr)
         `DLC_ADDR_CONTROL_ONE: begin
            reg_rdata[`DLC_BIT_SOFT_RESET] = 1'b0;
            reg_rdata[`DLC_BIT_ISO_LOOP] = iso_loop;
         end
         `DLC_ADDR_CONTROL_TWO: begin
            reg_rdata[`DLC_BIT_ECHO_LOOP] = echo_loop;
            reg_rdata[`DLC_BIT_HYBRID] = hybrid;
            reg_rdata[`DLC_BIT_RX_ON] = rx_on;
         end
         `DLC_ADDR_LINE_HOOK: begin
            reg_rdata[`DLC_BIT_RING_NEG] = ring_neg;
            reg_rdata[`DLC_BIT_RING_POS] = ring_pos;
            reg_rdata[`DLC_BIT_MONITOR] = monitor;
            reg_rdata[`DLC_BIT_RING_ACT] = ring_act;
            reg_rdata[`DLC_BIT_SEIZE] = seize;
         end
         default: reg_rdata = 8'h00;
      endcase
   end

endmodule // dlc_line_control
`default_nettype wire

// *** dlc_line_control_checker.sv ***
// Port assertions for the line control bank.
// Assumes bind onto dlc_line_control; sync active-high reset.
`default_nettype none
module dlc_checker(
   // Clock, reset, register port
   input wire logic clk, rst, reg_wr,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata,
   // Line side
   input wire logic ring_positive_in, ring_negative_in, hook_pin_gate, hook_pin,
   input wire logic quick_reseize_mode, hook_counter_done, line_offhook, hook_counter_start,
   input wire logic isolation_loopback_enable, line_echo_loopback, hybrid_connect,
   input wire logic receive_path_on, onhook_monitor_enable
);
   timeunit 1ns; timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire sr = reg_wr && reg_addr == 5'h01 && reg_wdata[7];
   sr_restore_a: assert property (sr |=> hybrid_connect && receive_path_on
      && !line_echo_loopback && !isolation_loopback_enable) else $error("soft reset");
   rsvd_zero_a: assert property (reg_addr != 5'h02 && reg_addr != 5'h05
      |-> (reg_rdata & 8'hfd) == 8'h00) else $error("reserved bits");
   iso_loop_a: assert property (reg_wr && reg_addr == 5'h01 && !reg_wdata[7]
      |=> isolation_loopback_enable == $past(reg_wdata[1])) else $error("iso loop");
   ctl_two_a: assert property (reg_wr && reg_addr == 5'h02 |=>
      {line_echo_loopback, hybrid_connect, receive_path_on}
      == {$past(reg_wdata[3]), $past(reg_wdata[1:0])}) else $error("control two");
   ring_flag_a: assert property (reg_addr == 5'h05 && !$past(sr) |->
      reg_rdata[6:5] == {$past(ring_negative_in), $past(ring_positive_in)})
      else $error("ring flags");
   ring_act_a: assert property ($past(ring_positive_in) && !$past(line_offhook)
      && !$past(sr) && reg_addr == 5'h05 |-> reg_rdata[2]) else $error("ring active");
   pin_seize_a: assert property ((hook_pin_gate && hook_pin && hook_counter_done && !sr)[*2]
      |-> line_offhook) else $error("pin seize");
   monitor_bit_a: assert property (reg_wr && reg_addr == 5'h05
      |=> onhook_monitor_enable == $past(reg_wdata[3])) else $error("monitor bit");
   hook_write_a: assert property (reg_wr && reg_addr == 5'h05 && hook_counter_done
      ##1 !reg_wr && hook_counter_done && !(hook_pin_gate && hook_pin)
      |=> line_offhook == $past(reg_wdata[0], 2)) else $error("hook write");
   count_start_a: assert property ($fell(line_offhook) && !$past(quick_reseize_mode)
      && !$past(sr) |-> hook_counter_start) else $error("counter start");
   quick_skip_a: assert property (quick_reseize_mode[*2] |-> !hook_counter_start)
      else $error("quick mode");
endmodule // dlc_checker
bind dlc_line_control dlc_checker u_chk(.*);
`default_nettype wire

// *** dlc_line_model.sv ***
// Line-side off-hook counter model.
// Assumes start is a one-cycle pulse from the bank.
`default_nettype none
module dlc_line_model #(parameter int N = 8) (
   input wire logic clk, rst, hook_counter_start,
   output logic hook_counter_done
);
   timeunit 1ns; timeprecision 1ps;
   logic [3:0] cnt;
   // Busy already in the start cycle, so a fast re-seize cannot slip through
   assign hook_counter_done = cnt == 4'h0 && !hook_counter_start;
   always @(posedge clk) begin
      if (rst) cnt <= 4'h0;
      else if (hook_counter_start) cnt <= 4'(N);
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
endmodule // dlc_line_model
`default_nettype wire

// *** tb_top.sv ***
// Register-level bench for the line control bank.
// Assumes the line model for the off-hook counter.
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
   timeunit 1ns; timeprecision 1ps;
   localparam int HOLD = 20;
   logic clk = 0, rst = 1, reg_wr = 0, rneg = 0, rpos = 0, gate = 0, pin = 0, quick = 0;
   logic [4:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   wire [7:0] reg_rdata;
   wire iso, echo, hyb, rx, mon, offhook, start, done;
   int miscompares = 0, tests_run = 0;
   logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
   always #12.5 clk = ~clk;
   dlc_line_control #(.RING_HOLD_CYCLES(HOLD)) u_dut(.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ring_negative_in(rneg), .ring_positive_in(rpos), .hook_pin_gate(gate),
      .hook_pin(pin), .quick_reseize_mode(quick), .hook_counter_done(done),
      .isolation_loopback_enable(iso), .line_echo_loopback(echo), .hybrid_connect(hyb),
      .receive_path_on(rx), .onhook_monitor_enable(mon), .line_offhook(offhook),
      .hook_counter_start(start));
   dlc_line_model u_line(.clk(clk), .rst(rst), .hook_counter_start(start),
      .hook_counter_done(done));
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk) reg_addr <= a;
      @(negedge clk) `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      for (int a = 0; a < 6; a++) rd(a[4:0], rv[a]);
      // Line side taken as powered up; one test mode at a time
      wr(1, 8'h02); rd(1, 8'h02); `CHK("iso", 1'b1, iso)
      wr(1, 8'h00); wr(2, 8'h0a); rd(2, 8'h0a); `CHK("echo_rx", 2'b10, {echo, rx})
      wr(2, 8'h01); rd(2, 8'h01); `CHK("hybrid", 1'b0, hyb)
      wr(3, 8'hff); wr(4, 8'hff); wr(0, 8'hff); rd(3, 0); rd(4, 0); rd(0, 0);
      wr(1, 8'hff); rd(1, 8'h00); rd(2, 8'h03);
      @(posedge clk) begin rpos <= 1; rneg <= 1; end
      rd(5, 8'h64);
      @(posedge clk) begin rpos <= 0; rneg <= 0; end
      repeat (HOLD - 2) @(posedge clk);
      rd(5, 8'h04);
      repeat (4) @(posedge clk);
      rd(5, 8'h00);
      @(posedge clk) rpos <= 1;
      @(posedge clk) rpos <= 0;
      wr(5, 8'h01); repeat (2) @(posedge clk); rd(5, 8'h01);
      @(posedge clk) quick <= 1'b1;
      wr(5, 8'h00); repeat (2) @(posedge clk);
      quick <= 1'b0;
      wr(5, 8'h08); rd(5, 8'h08); `CHK("monitor", 1'b1, mon)
      wr(5, 8'h00); wr(5, 8'h01); rd(5, 8'h01); `CHK("reseize", 1'b1, offhook)
      wr(5, 8'h00); wr(5, 8'h01);
      repeat (4) @(negedge clk);
      `CHK("wait", 1'b0, offhook)
      repeat (9) @(negedge clk);
      `CHK("seized", 1'b1, offhook)
      wr(5, 8'h00);
      @(posedge clk) begin gate <= 1; pin <= 1; end
      repeat (14) @(negedge clk);
      `CHK("pin", 1'b1, offhook)
      @(posedge clk) pin <= 0;
      repeat (3) @(negedge clk);
      `CHK("pin_off", 1'b0, offhook)
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
